// file: logic/wpo_pkg.sv
package wpo_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] WPO_OFF_CTRL     = 12'h000;
  localparam logic [11:0] WPO_OFF_STATUS   = 12'h004;
  localparam logic [11:0] WPO_OFF_BASIC    = 12'h008;
  localparam logic [11:0] WPO_OFF_PM       = 12'h00c;
  localparam logic [11:0] WPO_OFF_OCT1     = 12'h010;
  localparam logic [11:0] WPO_OFF_OCT2     = 12'h014;
  localparam logic [11:0] WPO_OFF_TX_TRACE = 12'h100;
  localparam logic [11:0] WPO_OFF_RX_TRACE = 12'h200;
  localparam logic [11:0] WPO_TRACE_SPAN   = 12'h040;

  // ----------------------------------------------------------------
  // control and status field positions
  // ----------------------------------------------------------------
  localparam int WPO_CTRL_TXLEN_LSB = 0;
  localparam int WPO_CTRL_RXLEN_LSB = 2;
  localparam int WPO_CTRL_BLK       = 4;
  localparam int WPO_CTRL_TXEN      = 5;
  localparam int WPO_CTRL_ERDI      = 6;
  localparam int WPO_CTRL_MASKA     = 7;
  localparam int WPO_CTRL_MASKB     = 8;
  localparam int WPO_STAT_PEND      = 0;
  localparam int WPO_STAT_LIVE      = 1;

  // ----------------------------------------------------------------
  // reset values and fixed octets
  // ----------------------------------------------------------------
  localparam logic [8:0]  WPO_CTRL_RST      = 9'h040;
  localparam logic [31:0] WPO_OCT1_RST      = 32'h0000001a;
  localparam logic [31:0] WPO_OCT2_RST      = 32'h00000000;
  localparam logic [7:0]  WPO_TRACE_HEADER  = 8'h89;
  localparam int          WPO_TRACE_OCTETS  = 64;
  localparam int          WPO_TRACE_BASE    = 16;

  // ----------------------------------------------------------------
  // trace length encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WPO_LEN_16 = 2'h0,
    WPO_LEN_1  = 2'h1,
    WPO_LEN_64 = 2'h2
  } wpo_len_t;
endpackage

// file: logic/wpo_path_overhead.sv
`timescale 1ns/1ps
// How it works
// RULE1: transmit trace octet cycles 1, 16 or 64 octets per length setting.
// RULE2: trace disabled sends header 0x89 then fifteen zero octets.
// RULE3: software writes 0x89 itself; trace storage resets to zero.
// RULE4: receive trace stores as repeating 16 octets, no boundary search.
// RULE5: transmit and receive trace lengths are set separately.
// RULE6: 64-octet transmit takes octets 0-15 base, 16-63 extended.
// RULE7: 64-octet receive stores octets 0-15 base, 16-63 extended.
// RULE8: receive trace storage takes one new octet per frame.
// RULE9: software does persistence and expected-message checks.
// RULE10: transmit parity over previous payload goes in next frame.
// RULE11: receive parity of a frame is checked against next frame's octet.
// RULE12: basic error counter adds one per errored frame and rolls over.
// RULE13: basic error counter clears only on reset.
// RULE14: 32-bit counter saturates, latched and cleared on each tick.
// RULE15: nonzero latched count sets sticky pending and live status.
// RULE16: pending drives two interrupt outputs, each with its own mask.
// RULE17: block mode counts one per errored frame, else each bit error.
// RULE18: error counts cross through a FIFO; excess counts are dropped.
// RULE19: no count available means zero error indication is sent.
// RULE20: FIFO overflow or underflow is not reported.
// RULE21: label, user, multiframe, growth and spare octets are programmed.
// RULE22: status octet selects one-bit or three-bit defect format.
// RULE23: error indication count sits in the top four status bits.
// RULE24: tick pulse is registered before it latches the counter.
module wpo_path_overhead #(
  parameter int LANES      = 1,
  parameter int BASIC_W    = 16,
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // apb slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // transmit frame side
  input  wire logic                 tx_frame_start_i,
  input  wire logic                 tx_spe_valid_i,
  input  wire logic [8*LANES-1:0]   tx_spe_data_i,
  output logic      [7:0]           tx_j1_o,
  output logic      [7:0]           tx_b3_o,
  output logic      [7:0]           tx_c2_o,
  output logic      [7:0]           tx_g1_o,
  output logic      [7:0]           tx_user_channel_octet_o,
  output logic      [7:0]           tx_multiframe_octet_o,
  output logic      [7:0]           tx_growth_octet_a_o,
  output logic      [7:0]           tx_growth_octet_b_o,
  output logic      [7:0]           tx_spare_path_octet_o,
  // receive frame side
  input  wire logic                 rx_frame_start_i,
  input  wire logic                 rx_spe_valid_i,
  input  wire logic [8*LANES-1:0]   rx_spe_data_i,
  input  wire logic                 rx_poh_valid_i,
  input  wire logic [7:0]           rx_j1_i,
  input  wire logic [7:0]           rx_b3_i,
  // monitoring
  input  wire logic                 perf_monitor_tick_i,
  output logic                      irq_out_a_o,
  output logic                      irq_out_b_o
);
  import wpo_pkg::*;

  localparam int FPW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [8:0]          ctrl_r;
  logic [31:0]         oct1_r;
  logic [31:0]         oct2_r;
  logic [7:0]          tx_trace_r [WPO_TRACE_OCTETS];
  logic [7:0]          rx_trace_r [WPO_TRACE_OCTETS];
  logic [5:0]          tx_ptr_r;
  logic [5:0]          rx_ptr_r;
  logic [7:0]          tx_acc_r;
  logic [7:0]          rx_acc_r;
  logic [7:0]          rx_prev_r;
  logic                rx_have_prev_r;
  logic [BASIC_W-1:0]  basic_cnt_r;
  logic [31:0]         pm_acc_r;
  logic [31:0]         pm_latch_r;
  logic                tick_r;
  logic                pend_r;
  logic [3:0]          fifo_mem_r [FIFO_DEPTH];
  logic [FPW-1:0]      fifo_wp_r;
  logic [FPW-1:0]      fifo_rp_r;
  logic [FPW:0]        fifo_cnt_r;
  logic [7:0]          tx_lane_x;
  logic [7:0]          rx_lane_x;
  logic                chk;
  logic [7:0]          diff;
  logic [3:0]          err_bits;
  logic                errored;
  logic [31:0]         pm_inc;
  logic [32:0]         pm_sum;
  logic [31:0]         pm_nxt;
  logic                live;
  logic                wr_en;
  logic                rd_en;
  logic                fifo_full;
  logic                fifo_empty;
  logic                fifo_push;
  logic                fifo_pop;
  logic [3:0]          rei;
  logic [5:0]          tx_ptr_nxt;
  logic [5:0]          rx_ptr_nxt;
  logic [5:0]          tx_idx;
  logic [5:0]          rx_idx;
  logic                addr_tx_trace;
  logic                addr_rx_trace;
  logic [3:0]          word_idx;

  // ----------------------------------------------------------------
  // lane parity folding
  // ----------------------------------------------------------------
  always_comb begin
    tx_lane_x = 8'h00;
    rx_lane_x = 8'h00;
    for (int i = 0; i < LANES; i++) begin
      tx_lane_x = tx_lane_x ^ tx_spe_data_i[8*i +: 8];
      rx_lane_x = rx_lane_x ^ rx_spe_data_i[8*i +: 8];
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign wr_en         = psel_i && penable_i && pwrite_i;
  assign rd_en         = psel_i && penable_i && !pwrite_i;
  assign pready_o      = 1'b1; // zero wait state, every access ends in one cycle
  assign addr_tx_trace = (paddr_i >= WPO_OFF_TX_TRACE)
                         && (paddr_i < WPO_OFF_TX_TRACE + WPO_TRACE_SPAN);
  assign addr_rx_trace = (paddr_i >= WPO_OFF_RX_TRACE)
                         && (paddr_i < WPO_OFF_RX_TRACE + WPO_TRACE_SPAN);
  assign word_idx      = paddr_i[5:2];

  // read mux; unmapped or misaligned addresses answer with an error
  always_comb begin
    prdata_o  = 32'h0;
    pslverr_o = 1'b0;
    if (paddr_i[1:0] != 2'h0) begin
      pslverr_o = psel_i;
    end else if (addr_tx_trace) begin
      for (int b = 0; b < 4; b++) begin
        prdata_o[8*b +: 8] = tx_trace_r[{word_idx, 2'(b)}];
      end
    end else if (addr_rx_trace) begin
      for (int b = 0; b < 4; b++) begin
        prdata_o[8*b +: 8] = rx_trace_r[{word_idx, 2'(b)}];
      end
    end else begin
      case (paddr_i)
        WPO_OFF_CTRL:   prdata_o = {23'h0, ctrl_r};
        WPO_OFF_STATUS: prdata_o = {30'h0, live, pend_r};
        WPO_OFF_BASIC:  prdata_o = 32'(basic_cnt_r);
        WPO_OFF_PM:     prdata_o = pm_latch_r;
        WPO_OFF_OCT1:   prdata_o = oct1_r;
        WPO_OFF_OCT2:   prdata_o = oct2_r;
        default:        pslverr_o = psel_i;
      endcase
    end
  end

  // control and static octet registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= WPO_CTRL_RST;
      oct1_r <= WPO_OCT1_RST; // [RULE21]
      oct2_r <= WPO_OCT2_RST;
    end else if (wr_en) begin
      case (paddr_i)
        WPO_OFF_CTRL: ctrl_r <= pwdata_i[8:0]; // [RULE5]
        WPO_OFF_OCT1: oct1_r <= pwdata_i;
        WPO_OFF_OCT2: oct2_r <= pwdata_i;
        default:      ;
      endcase
    end
  end

  // transmit trace storage; reset leaves no header octet in it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WPO_TRACE_OCTETS; i++) begin
        tx_trace_r[i] <= 8'h00; // [RULE3]
      end
    end else if (wr_en && addr_tx_trace && paddr_i[1:0] == 2'h0) begin
      for (int b = 0; b < 4; b++) begin
        tx_trace_r[{word_idx, 2'(b)}] <= pwdata_i[8*b +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit trace, parity and octet insertion
  // ----------------------------------------------------------------
  // pointer wraps by length; 1-octet mode pins it at zero
  always_comb begin
    case (wpo_len_t'(ctrl_r[WPO_CTRL_TXLEN_LSB +: 2]))
      WPO_LEN_1:  tx_ptr_nxt = 6'h00;                        // [RULE1]
      WPO_LEN_64: tx_ptr_nxt = tx_ptr_r + 6'h01;              // [RULE6]
      default:    tx_ptr_nxt = {2'h0, tx_ptr_r[3:0] + 4'h1};
    endcase
    case (wpo_len_t'(ctrl_r[WPO_CTRL_RXLEN_LSB +: 2]))
      WPO_LEN_1:  rx_ptr_nxt = 6'h00;
      WPO_LEN_64: rx_ptr_nxt = rx_ptr_r + 6'h01;              // [RULE7]
      default:    rx_ptr_nxt = {2'h0, rx_ptr_r[3:0] + 4'h1};  // [RULE4]
    endcase
  end
  assign tx_idx = (wpo_len_t'(ctrl_r[WPO_CTRL_TXLEN_LSB +: 2]) == WPO_LEN_64)
                  ? tx_ptr_r : {2'h0, tx_ptr_r[3:0]};
  assign rx_idx = (wpo_len_t'(ctrl_r[WPO_CTRL_RXLEN_LSB +: 2]) == WPO_LEN_64)
                  ? rx_ptr_r : {2'h0, rx_ptr_r[3:0]};

  // tx parity accumulates per frame; the frame-start beat opens a new frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_acc_r <= 8'h00;
    end else if (tx_frame_start_i) begin
      tx_acc_r <= tx_spe_valid_i ? tx_lane_x : 8'h00;
    end else if (tx_spe_valid_i) begin
      tx_acc_r <= tx_acc_r ^ tx_lane_x; // even parity per bit column
    end
  end

  // all path octets change only at frame start so a frame carries one set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ptr_r <= 6'h00;
      tx_j1_o  <= 8'h00;
      tx_b3_o  <= 8'h00;
      tx_c2_o  <= WPO_OCT1_RST[7:0];
      tx_g1_o  <= 8'h00;
      tx_user_channel_octet_o  <= 8'h00;
      tx_multiframe_octet_o  <= 8'h00;
      tx_growth_octet_a_o  <= 8'h00;
      tx_growth_octet_b_o  <= 8'h00;
      tx_spare_path_octet_o  <= 8'h00;
    end else if (tx_frame_start_i) begin
      tx_ptr_r <= ctrl_r[WPO_CTRL_TXEN] ? tx_ptr_nxt : {2'h0, tx_ptr_r[3:0] + 4'h1};
      if (ctrl_r[WPO_CTRL_TXEN]) begin
        tx_j1_o <= tx_trace_r[tx_idx]; // [RULE1]
      end else begin
        tx_j1_o <= (tx_ptr_r[3:0] == 4'h0) ? WPO_TRACE_HEADER : 8'h00; // [RULE2]
      end
      tx_b3_o <= tx_acc_r; // [RULE10]
      tx_c2_o <= oct1_r[7:0]; // [RULE21]
      tx_user_channel_octet_o <= oct1_r[15:8];
      tx_multiframe_octet_o <= oct1_r[23:16];
      tx_growth_octet_a_o <= oct1_r[31:24];
      tx_growth_octet_b_o <= oct2_r[7:0];
      tx_spare_path_octet_o <= oct2_r[15:8];
      if (ctrl_r[WPO_CTRL_ERDI]) begin
        tx_g1_o <= {rei, oct2_r[18:16], 1'b0}; // [RULE22] [RULE23]
      end else begin
        tx_g1_o <= {rei, oct2_r[18], 3'h0}; // one-bit form, reserved bits zero
      end
    end
  end

  // ----------------------------------------------------------------
  // receive parity check and trace capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_acc_r       <= 8'h00;
      rx_prev_r      <= 8'h00;
      rx_have_prev_r <= 1'b0;
    end else if (rx_frame_start_i) begin
      rx_prev_r      <= rx_acc_r; // [RULE11]
      rx_have_prev_r <= 1'b1;
      rx_acc_r       <= rx_spe_valid_i ? rx_lane_x : 8'h00;
    end else if (rx_spe_valid_i) begin
      rx_acc_r <= rx_acc_r ^ rx_lane_x;
    end
  end

  // path octets before the first frame start after reset have nothing to compare against
  assign chk     = rx_poh_valid_i && rx_have_prev_r;
  assign diff    = rx_b3_i ^ rx_prev_r; // [RULE11]
  assign errored = chk && (diff != 8'h00);
  always_comb begin
    err_bits = 4'h0;
    for (int i = 0; i < 8; i++) begin
      err_bits = err_bits + 4'(diff[i]);
    end
  end

  // no boundary search: storage may look rotated after realignment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ptr_r <= 6'h00;
      for (int i = 0; i < WPO_TRACE_OCTETS; i++) begin
        rx_trace_r[i] <= 8'h00;
      end
    end else if (rx_poh_valid_i) begin
      rx_trace_r[rx_idx] <= rx_j1_i; // [RULE8] [RULE4]
      rx_ptr_r           <= rx_ptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // error counters
  // ----------------------------------------------------------------
  // basic counter: block count, rolls over, only reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      basic_cnt_r <= '0; // [RULE13]
    end else if (errored) begin
      basic_cnt_r <= basic_cnt_r + BASIC_W'(1); // [RULE12]
    end
  end

  assign pm_inc = !chk ? 32'h0 :
                  ctrl_r[WPO_CTRL_BLK] ? 32'(errored) : 32'(err_bits); // [RULE17]
  assign pm_sum = {1'b0, pm_acc_r} + {1'b0, pm_inc};
  assign pm_nxt = pm_sum[32] ? 32'hffffffff : pm_sum[31:0]; // [RULE14]

  // tick is registered once; errors in the tick cycle go to the latched value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r     <= 1'b0;
      pm_acc_r   <= 32'h0;
      pm_latch_r <= 32'h0;
    end else begin
      tick_r <= perf_monitor_tick_i; // [RULE24]
      if (tick_r) begin
        pm_latch_r <= pm_nxt; // [RULE14]
        pm_acc_r   <= 32'h0;
      end else begin
        pm_acc_r <= pm_nxt;
      end
    end
  end

  // pending is sticky; a set in the clearing read cycle wins
  assign live = (pm_latch_r != 32'h0); // [RULE15]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
    end else if (live) begin
      pend_r <= 1'b1; // [RULE15]
    end else if (rd_en && paddr_i == WPO_OFF_STATUS) begin
      pend_r <= 1'b0;
    end
  end

  assign irq_out_a_o = pend_r && ctrl_r[WPO_CTRL_MASKA]; // [RULE16]
  assign irq_out_b_o = pend_r && ctrl_r[WPO_CTRL_MASKB]; // [RULE16]

  // ----------------------------------------------------------------
  // error count fifo toward the status octet
  // ----------------------------------------------------------------
  // full drops the new count unless a frame start pops in the same cycle, empty yields zero; neither is flagged
  assign fifo_full  = (fifo_cnt_r == (FPW+1)'(FIFO_DEPTH));
  assign fifo_empty = (fifo_cnt_r == '0);
  assign fifo_pop   = tx_frame_start_i && !fifo_empty;
  assign fifo_push  = chk && (!fifo_full || fifo_pop); // [RULE18] [RULE20]
  assign rei        = fifo_empty ? 4'h0 : fifo_mem_r[fifo_rp_r]; // [RULE19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_wp_r  <= '0;
      fifo_rp_r  <= '0;
      fifo_cnt_r <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem_r[i] <= 4'h0;
      end
    end else begin
      if (fifo_push) begin
        fifo_mem_r[fifo_wp_r] <= err_bits;
        fifo_wp_r <= (fifo_wp_r == FPW'(FIFO_DEPTH-1)) ? '0 : fifo_wp_r + FPW'(1);
      end
      if (fifo_pop) begin
        fifo_rp_r <= (fifo_rp_r == FPW'(FIFO_DEPTH-1)) ? '0 : fifo_rp_r + FPW'(1);
      end
      fifo_cnt_r <= fifo_cnt_r + (FPW+1)'(fifo_push) - (FPW+1)'(fifo_pop);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tick_seen;
    tick_r;
  endsequence
  sequence s_clean_acc;
    pm_acc_r == 32'h0;
  endsequence

  // a read that lands just as the latch empties may clear pending one cycle later
  property p_pend_set;
    live |=> pend_r;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending lost"); // [RULE15]

  property p_pend_hold;
    pend_r && !(rd_en && paddr_i == WPO_OFF_STATUS) |=> pend_r;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped unread"); // [RULE15]

  property p_basic_step;
    errored |=> basic_cnt_r == $past(basic_cnt_r) + BASIC_W'(1);
  endproperty
  a_basic_step: assert property (p_basic_step) else $error("basic count step"); // [RULE12]

  property p_basic_hold;
    !errored |=> $stable(basic_cnt_r);
  endproperty
  a_basic_hold: assert property (p_basic_hold) else $error("basic count moved"); // [RULE13]

  property p_pm_latch;
    s_tick_seen |=> s_clean_acc and (pm_latch_r == $past(pm_nxt));
  endproperty
  a_pm_latch: assert property (p_pm_latch) else $error("tick latch wrong"); // [RULE14]

  property p_blk_mode;
    ctrl_r[WPO_CTRL_BLK] && chk && !tick_r |=> pm_acc_r <= $past(pm_acc_r) + 32'h1;
  endproperty
  a_blk_mode: assert property (p_blk_mode) else $error("block mode over count"); // [RULE17]

  property p_rei_zero;
    tx_frame_start_i && fifo_empty |=> tx_g1_o[7:4] == 4'h0;
  endproperty
  a_rei_zero: assert property (p_rei_zero) else $error("rei not zero"); // [RULE19]

  property p_default_hdr;
    tx_frame_start_i && !ctrl_r[WPO_CTRL_TXEN] && tx_ptr_r[3:0] == 4'h0
      |=> tx_j1_o == WPO_TRACE_HEADER;
  endproperty
  a_default_hdr: assert property (p_default_hdr) else $error("default header"); // [RULE2]

  property p_b3_insert;
    tx_frame_start_i |=> tx_b3_o == $past(tx_acc_r) ##1 $stable(tx_b3_o) || $past(tx_frame_start_i);
  endproperty
  a_b3_insert: assert property (p_b3_insert) else $error("b3 not inserted"); // [RULE10]

  property p_irq_mask;
    irq_out_a_o || irq_out_b_o |-> pend_r;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq without pending"); // [RULE16]

  property p_fifo_bound;
    fifo_cnt_r <= (FPW+1)'(FIFO_DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled"); // [RULE18]
endmodule

// file: test/wpo_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-end path terminal: builds frames for the receive side
// ----------------------------------------------------------------
module wpo_far_end (
  // clock
  input  wire logic       clk_i,
  // frames toward the block
  output logic            rx_frame_start_o,
  output logic            rx_spe_valid_o,
  output logic [7:0]      rx_spe_data_o,
  output logic            rx_poh_valid_o,
  output logic [7:0]      rx_j1_o,
  output logic [7:0]      rx_b3_o
);
  logic [7:0] par_r = 8'h00;
  logic [7:0] pat_r = 8'h5a;

  // lines start idle before the first frame
  initial begin
    {rx_frame_start_o, rx_spe_valid_o, rx_poh_valid_o} = 3'h0;
    {rx_spe_data_o, rx_j1_o, rx_b3_o} = 24'h0;
  end

  // one frame: start, four payload beats, then the path octets;
  // err flips parity bits so the block sees that many bit errors
  task automatic send(input logic [7:0] j1, input logic [7:0] err);
    logic [7:0] prev;
    prev = par_r;
    @(posedge clk_i);
    rx_frame_start_o <= 1'b1;
    par_r = 8'h00;
    repeat (4) begin
      @(posedge clk_i);
      rx_frame_start_o <= 1'b0;
      rx_spe_valid_o <= 1'b1;
      rx_spe_data_o <= pat_r;
      par_r = par_r ^ pat_r;
      pat_r = pat_r + 8'h3b;
    end
    @(posedge clk_i);
    rx_spe_valid_o <= 1'b0;
    rx_spe_data_o <= ~rx_spe_data_o; // released data never repeats
    rx_poh_valid_o <= 1'b1;
    rx_j1_o <= j1;
    rx_b3_o <= prev ^ err;
    @(posedge clk_i);
    rx_poh_valid_o <= 1'b0;
    rx_j1_o <= ~j1;
    rx_b3_o <= ~rx_b3_o;
  endtask
endmodule

// file: test/wpo_path_overhead_tb.sv
`timescale 1ns/1ps
module wpo_path_overhead_tb;
  import wpo_pkg::*;
  logic        clk_i, rst_i, psel, penable, pwrite, tx_start, tx_val, tick, serr;
  logic        pready, pslverr, irq_a, irq_b, rx_fs, rx_v, rx_pv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  tx_dat, j1, b3, c2, g1, f2, h4, z3, z4, n1, rx_d, rx_j1, rx_b3, pat, par, prev;
  logic [7:0]  oct [64];
  int          error_cnt = 0;
  int          cmp_count = 0;

  wpo_path_overhead u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_frame_start_i(tx_start), .tx_spe_valid_i(tx_val),
    .tx_spe_data_i(tx_dat), .tx_j1_o(j1), .tx_b3_o(b3), .tx_c2_o(c2), .tx_g1_o(g1),
    .tx_user_channel_octet_o(f2), .tx_multiframe_octet_o(h4), .tx_growth_octet_a_o(z3), .tx_growth_octet_b_o(z4), .tx_spare_path_octet_o(n1),
    .rx_frame_start_i(rx_fs), .rx_spe_valid_i(rx_v), .rx_spe_data_i(rx_d),
    .rx_poh_valid_i(rx_pv), .rx_j1_i(rx_j1), .rx_b3_i(rx_b3),
    .perf_monitor_tick_i(tick), .irq_out_a_o(irq_a), .irq_out_b_o(irq_b));

  wpo_far_end u_far (
    .clk_i(clk_i), .rx_frame_start_o(rx_fs), .rx_spe_valid_o(rx_v), .rx_spe_data_o(rx_d),
    .rx_poh_valid_o(rx_pv), .rx_j1_o(rx_j1), .rx_b3_o(rx_b3));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // apb transfer; rd and serr are taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    serr = pslverr;
    if (n >= 50) begin
      error_cnt++;
      end_sim;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one transmit frame; b3 must carry the parity of the frame before
  task automatic tx_frame;
    @(posedge clk_i);
    tx_start <= 1'b1;
    prev = par;
    par = 8'h00;
    repeat (4) begin
      @(posedge clk_i);
      tx_start <= 1'b0;
      tx_val <= 1'b1;
      tx_dat <= pat;
      par = par ^ pat;
      pat = pat + 8'h29;
    end
    @(posedge clk_i);
    tx_val <= 1'b0;
    tx_dat <= ~tx_dat;
    chk(b3, prev);
  endtask

  task automatic pm_tick;
    @(posedge clk_i);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // receive trace may be rotated, so only octet succession is judged
  task automatic rx_check(input int n, input logic [7:0] first);
    logic [7:0] nx;
    for (int k = 0; k < n / 4; k++) begin
      apb(1'b0, WPO_OFF_RX_TRACE + 12'(4 * k), 32'h0);
      for (int b = 0; b < 4; b++) oct[4 * k + b] = rd[8 * b +: 8];
    end
    for (int i = 0; i < n; i++) begin
      nx = (oct[i] == first + 8'(n - 1)) ? first : oct[i] + 8'h01;
      chk(oct[(i + 1) % n], nx);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_static;
    chk(c2, 8'h1a);
    apb(1'b0, WPO_OFF_TX_TRACE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(serr, 1'b1);
    apb(1'b1, WPO_OFF_OCT1, 32'h44332211);
    apb(1'b1, WPO_OFF_OCT2, 32'h00056655);
    tx_frame;
    chk({c2, f2, h4, z3}, 32'h11223344);
    chk({z4, n1}, 16'h5566);
  endtask

  task automatic t_tx_trace;
    int cnt;
    int len;
    logic [7:0] last;
    cnt = 0;
    for (int k = 0; k < 16; k++)
      apb(1'b1, WPO_OFF_TX_TRACE + 12'(4 * k), 32'h43424140 + 32'h04040404 * k);
    repeat (16) begin
      tx_frame;
      if (j1 === WPO_TRACE_HEADER) cnt++;
      else chk(j1, 8'h00);
    end
    chk(cnt, 1);
    for (int m = 0; m < 3; m++) begin
      len = (m == 0) ? 16 : (m == 1) ? 1 : 64;
      apb(1'b1, WPO_OFF_CTRL, 32'h60 | m);
      tx_frame;
      repeat (66) begin
        last = j1;
        tx_frame;
        chk(j1, 64 + (last - 63) % len);
      end
    end
  endtask

  task automatic t_rx_trace;
    for (int n = 0; n < 16; n++) u_far.send(8'ha0 + 8'(n), 8'h00);
    rx_check(16, 8'ha0);
    apb(1'b1, WPO_OFF_CTRL, 32'h48);
    for (int n = 0; n < 64; n++) u_far.send(8'(n), 8'h00);
    rx_check(64, 8'h00);
    // one-octet mode overwrites the same slot; the rest keeps the 64-octet run
    apb(1'b1, WPO_OFF_CTRL, 32'h44);
    u_far.send(8'h77, 8'h00);
    u_far.send(8'h78, 8'h00);
    apb(1'b0, WPO_OFF_RX_TRACE, 32'h0);
    chk(rd, 32'h03020178);
  endtask

  // error counts cross a two-deep fifo into the top of the status octet
  task automatic t_g1;
    apb(1'b1, WPO_OFF_CTRL, 32'h40);
    repeat (3) tx_frame;
    u_far.send(8'h00, 8'h07);
    tx_frame;
    chk(g1, 8'h3a);
    tx_frame;
    chk(g1, 8'h0a);
    apb(1'b1, WPO_OFF_CTRL, 32'h00);
    u_far.send(8'h00, 8'h01);
    u_far.send(8'h00, 8'h03);
    u_far.send(8'h00, 8'h07);
    tx_frame;
    chk(g1, 8'h18);
    tx_frame;
    chk(g1, 8'h28);
    tx_frame;
    chk(g1, 8'h08);
  endtask

  task automatic t_counters;
    apb(1'b1, WPO_OFF_CTRL, 32'h0c0);
    pm_tick;
    chk({irq_a, irq_b}, 2'b10);
    apb(1'b0, WPO_OFF_BASIC, 32'h0);
    chk(rd, 32'd4);
    apb(1'b0, WPO_OFF_PM, 32'h0);
    chk(rd, 32'd9);
    apb(1'b0, WPO_OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, WPO_OFF_CTRL, 32'h150);
    @(posedge clk_i); // the mask write settles at the edge the task returns on
    chk({irq_a, irq_b}, 2'b01);
    u_far.send(8'h00, 8'hff);
    u_far.send(8'h00, 8'h81);
    pm_tick;
    apb(1'b0, WPO_OFF_PM, 32'h0);
    chk(rd, 32'd2);
    apb(1'b0, WPO_OFF_BASIC, 32'h0);
    chk(rd, 32'd6);
    pm_tick;
    apb(1'b0, WPO_OFF_PM, 32'h0);
    chk(rd, 32'd0);
    apb(1'b0, WPO_OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, WPO_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    // a mid-run reset is the only thing that may clear the basic counter
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, WPO_OFF_BASIC, 32'h0);
    chk(rd, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // clock, main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, psel, penable, pwrite, tx_start, tx_val, tick} = 7'h40;
    {paddr, pwdata, tx_dat, par} = 60'h0;
    pat = 8'h11;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_static;
    t_tx_trace;
    t_rx_trace;
    t_g1;
    t_counters;
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    end_sim;
  end
endmodule
